/* File: rtl/ddcm_pkg.sv */
// Shared constants and carrier types for the oscillator and mixer stage
package ddcm_pkg;
   // Datapath widths
   localparam int ACC_W    = 32;
   localparam int POFF_W   = 16;
   localparam int SAMP_W   = 12;
   localparam int OUT_W    = 16;
   localparam int NUM_OSC  = 4;
   localparam int NUM_CH   = 2;
   localparam int SEL_W    = 2;
   localparam int LUT_W    = 4;
   localparam int PROD_LSB = 7;

   // Latencies in device clock cycles
   localparam int SAMP_LAT   = 36;
   localparam int SYNC_STG   = 2;
   localparam int HOP_LAT    = 36;
   localparam int HOP_DLY    = HOP_LAT - SYNC_STG;
   localparam int FIFO_DEPTH = 32;

   // Reset values and phase constants
   localparam logic [ACC_W-1:0]   ACC_RST  = 32'h0000_0000;
   localparam logic [POFF_W-1:0]  POFF_PAD = 16'h0000;
   localparam logic [LUT_W+1:0]   QUARTER  = 6'h10;

   // Quarter-wave sine magnitudes, entry k at index k
   localparam logic [15:0][SAMP_W-1:0] SIN_LUT = {
      12'h7F5, 12'h7D8, 12'h7A7, 12'h763, 12'h70D, 12'h6A6, 12'h62E, 12'h5A7,
      12'h513, 12'h471, 12'h3C5, 12'h30F, 12'h252, 12'h18F, 12'h0C9, 12'h000
   };

   typedef logic [NUM_OSC-1:0][ACC_W-1:0]  ddcm_freq_t;
   typedef logic [NUM_OSC-1:0][POFF_W-1:0] ddcm_poff_t;

   // Converter samples entering the stage
   typedef struct packed {
      logic              valid;
      logic [SAMP_W-1:0] a;
      logic [SAMP_W-1:0] b;
   } ddcm_samp_s;

   typedef struct packed {
      logic [OUT_W-1:0] i;
      logic [OUT_W-1:0] q;
   } ddcm_cplx_s;

   // Mixed output word for both channels
   typedef struct packed {
      ddcm_cplx_s a;
      ddcm_cplx_s b;
   } ddcm_pair_s;
endpackage

/* File: rtl/ddcm_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ddcm_fifo #(
   parameter int W     = 64,
   parameter int DEPTH = 32
) (
   input  wire logic         mclk_i,
   input  wire logic         arst_n_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
   } ddcm_fifo_s;

   ddcm_fifo_s s_q;
   ddcm_fifo_s s_d;
   logic       full;
   logic       empty;

   // Honest full and empty from wrap-bit pointers
   assign full  = (s_q.wp[AW] != s_q.rp[AW]) &&
                  (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
   assign empty = (s_q.wp == s_q.rp);
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = s_q.mem[s_q.rp[AW-1:0]];

   // Pointer and storage update
   always_comb begin
      s_d = s_q;
      if (in_valid_i && !full) begin
         s_d.mem[s_q.wp[AW-1:0]] = in_data_i;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (out_ready_i && !empty) begin
         s_d.rp = s_q.rp + 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

/* File: rtl/ddcm_mixer.sv */
// Four-oscillator hop-select NCO and complex mixer for both channels
`timescale 1ns/1ps
module ddcm_mixer #(
   parameter int DEPTH = ddcm_pkg::FIFO_DEPTH
) (
   input  wire logic                        mclk_i,
   input  wire logic                        arst_n_i,
   input  wire logic                        dual_mode_i,
   input  wire logic                        chan_a_bypass_i,
   input  wire logic                        chan_b_bypass_i,
   input  wire logic                        chan_b_input_binding_i,
   input  wire logic                        select_source_mode_i,
   input  wire logic [ddcm_pkg::SEL_W-1:0]  chan_a_register_select_i,
   input  wire logic [ddcm_pkg::SEL_W-1:0]  chan_b_register_select_i,
   input  wire logic                        chan_a_hop_pin0_i,
   input  wire logic                        chan_a_hop_pin1_i,
   input  wire logic                        chan_b_hop_pin0_i,
   input  wire logic                        chan_b_hop_pin1_i,
   input  wire ddcm_pkg::ddcm_freq_t        chan_a_freq_word_i,
   input  wire ddcm_pkg::ddcm_freq_t        chan_b_freq_word_i,
   input  wire ddcm_pkg::ddcm_poff_t        chan_a_phase_offset_i,
   input  wire ddcm_pkg::ddcm_poff_t        chan_b_phase_offset_i,
   input  wire logic                        sync_on_next_marker_i,
   input  wire logic                        sync_on_link_init_i,
   input  wire logic                        sysref_i,
   input  wire logic                        link_init_i,
   input  wire ddcm_pkg::ddcm_samp_s        samp_i,
   output logic                             in_ready_o,
   output logic                             out_valid_o,
   input  wire logic                        out_ready_i,
   output ddcm_pkg::ddcm_pair_s             out_data_o
);
   import ddcm_pkg::*;

   typedef struct packed {
      logic [NUM_CH-1:0][NUM_OSC-1:0][ACC_W-1:0] acc;
      logic [NUM_CH-1:0][SEL_W-1:0]              hop_s1;
      logic [NUM_CH-1:0][SEL_W-1:0]              hop_s2;
      logic [HOP_DLY-1:0][NUM_CH-1:0][SEL_W-1:0] hop_dly;
      logic [SAMP_LAT-1:0][NUM_CH-1:0][SAMP_W-1:0] smp;
      logic [SAMP_LAT-1:0]                       vld;
      logic                                      sysref_q;
      logic                                      arm_prev;
      logic                                      armed;
      ddcm_pair_s                                mix;
      logic                                      mix_v;
   } ddcm_state_s;

   ddcm_state_s                   s_q;
   ddcm_state_s                   s_d;
   logic [NUM_CH-1:0][SEL_W-1:0]  pins;
   logic [NUM_CH-1:0][SEL_W-1:0]  regsel;
   logic [NUM_CH-1:0][SEL_W-1:0]  sel;
   logic [NUM_CH-1:0]             byp;
   ddcm_freq_t [NUM_CH-1:0]       freq;
   ddcm_poff_t [NUM_CH-1:0]       poff;
   logic [NUM_CH-1:0][SAMP_W-1:0] smp_in;
   ddcm_cplx_s [NUM_CH-1:0]       mixed;
   logic                          advance;
   logic                          fifo_ready;
   logic                          arm_rise;
   logic                          marker;
   logic                          link_sync;
   logic                          sync_fire;

   // Phase-to-amplitude from a quarter-wave table
   function automatic logic [SAMP_W-1:0] ddcm_sin(
      input logic [LUT_W+1:0] p
   );
      logic [LUT_W-1:0]  idx;
      logic [SAMP_W-1:0] mag;
      idx = p[LUT_W] ? ~p[LUT_W-1:0] : p[LUT_W-1:0];
      mag = SIN_LUT[idx];
      return p[LUT_W+1] ? -mag : mag;
   endfunction

   // Per-channel wiring of pins, fields, words and sources
   assign pins[0]   = {chan_a_hop_pin1_i, chan_a_hop_pin0_i};
   assign pins[1]   = {chan_b_hop_pin1_i, chan_b_hop_pin0_i};
   assign regsel[0] = chan_a_register_select_i;
   assign regsel[1] = chan_b_register_select_i;
   assign freq[0]   = chan_a_freq_word_i;
   assign freq[1]   = chan_b_freq_word_i;
   assign poff[0]   = chan_a_phase_offset_i;
   assign poff[1]   = chan_b_phase_offset_i;
   assign smp_in[0] = samp_i.a;
   assign smp_in[1] = chan_b_input_binding_i ? samp_i.a : samp_i.b;
   assign byp[0]    = !dual_mode_i || chan_a_bypass_i;
   assign byp[1]    = !dual_mode_i || chan_b_bypass_i;

   // Oscillator choice: delayed pins or register field
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         sel[c] = select_source_mode_i ? s_q.hop_dly[HOP_DLY-1][c]
                                       : regsel[c];
      end
   end

   // Accumulator sync sources; a new arm wins over its own use
   assign arm_rise  = sync_on_next_marker_i && !s_q.arm_prev;
   assign link_sync = sync_on_link_init_i && link_init_i;
   assign marker    = !sync_on_link_init_i && s_q.armed &&
                      sysref_i && !s_q.sysref_q;
   assign sync_fire = link_sync || marker;

   // Pipeline moves when the mix register can be emptied
   assign advance    = !s_q.mix_v || fifo_ready;
   assign in_ready_o = advance;

   // Mixer on the sample that has reached the last delay stage
   always_comb begin
      logic [ACC_W-1:0]      ph;
      logic [SAMP_W-1:0]     cs;
      logic [SAMP_W-1:0]     sn;
      logic [SAMP_W-1:0]     x;
      logic [2*SAMP_W-1:0]   pi_p;
      logic [2*SAMP_W-1:0]   pq_p;
      ph   = '0;
      cs   = '0;
      sn   = '0;
      x    = '0;
      pi_p = '0;
      pq_p = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         ph = s_q.acc[c][sel[c]] + {poff[c][sel[c]], POFF_PAD};
         sn = ddcm_sin(ph[ACC_W-1 -: LUT_W+2]);
         cs = ddcm_sin(ph[ACC_W-1 -: LUT_W+2] + QUARTER);
         x  = s_q.smp[SAMP_LAT-1][c];
         pi_p = $signed(x) * $signed(cs);
         pq_p = $signed(x) * $signed(sn);
         if (byp[c]) begin
            mixed[c].i = {x, {(OUT_W-SAMP_W){1'b0}}};
            mixed[c].q = '0;
         end else begin
            mixed[c].i = pi_p[PROD_LSB +: OUT_W];
            mixed[c].q = pq_p[PROD_LSB +: OUT_W];
         end
      end
   end

   // Next state of the whole stage
   always_comb begin
      s_d = s_q;
      // Free-running accumulators, cleared only by sync
      for (int c = 0; c < NUM_CH; c++) begin
         for (int k = 0; k < NUM_OSC; k++) begin
            s_d.acc[c][k] = sync_fire ? ACC_RST
                          : s_q.acc[c][k] + freq[c][k];
         end
      end
      // Hop pin synchronizer then fixed delay line
      s_d.hop_s1  = pins;
      s_d.hop_s2  = s_q.hop_s1;
      s_d.hop_dly = {s_q.hop_dly[HOP_DLY-2:0], s_q.hop_s2};
      // Marker edge detect and arming
      s_d.sysref_q = sysref_i;
      s_d.arm_prev = sync_on_next_marker_i;
      s_d.armed    = arm_rise || (s_q.armed && !marker);
      // Sample delay and mix register, held under back-pressure
      if (advance) begin
         s_d.smp   = {s_q.smp[SAMP_LAT-2:0], smp_in};
         s_d.vld   = {s_q.vld[SAMP_LAT-2:0], samp_i.valid};
         s_d.mix.a = mixed[0];
         s_d.mix.b = mixed[1];
         s_d.mix_v = s_q.vld[SAMP_LAT-1];
      end
   end

   // State register
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Output buffer towards the decimation and transmit path
   ddcm_fifo #(
      .W     ($bits(ddcm_pair_s)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (s_q.mix_v),
      .in_ready_o  (fifo_ready),
      .in_data_i   (s_q.mix),
      .out_valid_o (out_valid_o),
      .out_ready_i (out_ready_i),
      .out_data_o  (out_data_o)
   );

   // Helper counters: cycles since reset and unbroken advance run
   logic [5:0] up_cnt_q;
   logic [5:0] adv_run_q;
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         up_cnt_q  <= '0;
         adv_run_q <= '0;
      end else begin
         if (up_cnt_q != 6'h3F) begin
            up_cnt_q <= up_cnt_q + 6'h01;
         end
         if (!advance) begin
            adv_run_q <= '0;
         end else if (adv_run_q != 6'h3F) begin
            adv_run_q <= adv_run_q + 6'h01;
         end
      end
   end

   // Accumulator advance and sync checks
   acc_adv_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !sync_fire |=> s_q.acc[0][1] == $past(s_q.acc[0][1]) +
                     $past(chan_a_freq_word_i[1]))
      else $error("channel A oscillator 1 did not advance");
   acc_wrap_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !sync_fire |=> s_q.acc[1][3] == ACC_W'($past(s_q.acc[1][3]) +
                     $past(chan_b_freq_word_i[3])))
      else $error("channel B oscillator 3 did not wrap");
   sync_clear_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      sync_fire |=> s_q.acc == '0)
      else $error("sync did not clear accumulators");
   marker_use_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      s_q.armed && !sync_on_link_init_i && $rose(sysref_i) && !arm_rise
      |-> sync_fire ##1 !s_q.armed)
      else $error("armed marker did not fire once");

   // Selection source and latency checks
   hop_lat_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      select_source_mode_i && up_cnt_q > 6'h26
      |-> sel[0] == $past({chan_a_hop_pin1_i, chan_a_hop_pin0_i}, 36))
      else $error("channel A hop latency wrong");
   hop_lat_b: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      select_source_mode_i && up_cnt_q > 6'h26
      |-> sel[1] == $past({chan_b_hop_pin1_i, chan_b_hop_pin0_i}, 36))
      else $error("channel B hop latency wrong");
   reg_sel_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !select_source_mode_i |-> sel[0] == chan_a_register_select_i &&
                                sel[1] == chan_b_register_select_i)
      else $error("register select not used");

   // Sample path checks
   samp_lat_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      adv_run_q >= 6'h24 |-> s_q.vld[SAMP_LAT-1] == $past(samp_i.valid, 36))
      else $error("sample latency wrong");
   bypass_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      $past(advance) && !$past(dual_mode_i)
      |-> s_q.mix.a.q == '0 && s_q.mix.b.q == '0 &&
          s_q.mix.a.i == {$past(s_q.smp[SAMP_LAT-1][0]), 4'h0})
      else $error("single mode did not bypass");
   hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      s_q.mix_v && !fifo_ready |=> s_q.mix_v && $stable(s_q.mix))
      else $error("mix word lost under back-pressure");

   // Main scenarios
   hop_seen_c: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      select_source_mode_i && $changed(sel[0]));
   sync_seen_c: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      marker);
   full_seen_c: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      s_q.mix_v && !fifo_ready);
   mixed_out_c: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      out_valid_o && out_ready_i && dual_mode_i);
endmodule

/* File: testbench/ddcm_sink.sv */
// Downstream consumer model standing in for the decimation and link path
`timescale 1ns/1ps
module ddcm_sink (
   input  wire logic                 mclk_i,
   input  wire logic                 arst_n_i,
   input  wire logic                 out_valid_i,
   input  wire ddcm_pkg::ddcm_pair_s out_data_i,
   input  wire logic                 stall_i,
   input  wire logic                 slow_i,
   output logic                      out_ready_o,
   output logic                      got_o,
   output ddcm_pkg::ddcm_pair_s      word_o
);
   import ddcm_pkg::*;
   logic tog_q;
   // Ready held low while stalled, every other cycle when slow
   assign out_ready_o = !stall_i && (!slow_i || tog_q);
   // Capture each word popped from the stage, flag it for one cycle
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tog_q  <= 1'b0;
         got_o  <= 1'b0;
         word_o <= '0;
      end else begin
         tog_q <= ~tog_q;
         got_o <= out_valid_i && out_ready_o;
         if (out_valid_i && out_ready_o) begin
            word_o <= out_data_i;
         end
      end
   end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the hop-select oscillator and mixer stage
`timescale 1ns/1ps
module testbench;
   import ddcm_pkg::*;
   `define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
      $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
   typedef struct packed {
      logic              md;
      logic [SEL_W-1:0]  sel;
      logic [SAMP_W-1:0] xa;
      logic [SAMP_W-1:0] xb;
   } ddcm_row_s;
   // Mode, select code and samples for both channels
   localparam ddcm_row_s ROWS [8] = '{
      '{1'b0, 2'h0, 12'h7FF, 12'h800}, '{1'b0, 2'h1, 12'h800, 12'h7FF},
      '{1'b0, 2'h2, 12'h123, 12'hEDC}, '{1'b0, 2'h3, 12'hF00, 12'h0FF},
      '{1'b1, 2'h0, 12'h001, 12'hFFF}, '{1'b1, 2'h1, 12'h5A5, 12'hA5A},
      '{1'b1, 2'h2, 12'h7FF, 12'h000}, '{1'b1, 2'h3, 12'h800, 12'h400}};
   // Six-bit phase set by each oscillator's offset
   localparam int PH [4] = '{3, 53, 10, 63};
   logic             mclk_i   = 1'b0;
   logic             arst_n_i = 1'b0;
   logic             dual     = 1'b1;
   logic             byp_a    = 1'b0;
   logic             byp_b    = 1'b0;
   logic             bind_b   = 1'b0;
   logic             mode     = 1'b0;
   logic [SEL_W-1:0] rsel     = '0;
   logic [SEL_W-1:0] pins     = '0;
   logic [SEL_W-1:0] pins_b   = '0;
   ddcm_freq_t       fa       = '0;
   ddcm_freq_t       fb       = '0;
   ddcm_poff_t       oa       = {16'hFC00, 16'h2800, 16'hD400, 16'h0C00};
   ddcm_poff_t       ob       = {16'hFC00, 16'h2800, 16'hD400, 16'h0C00};
   logic             snm      = 1'b0;
   logic             sli      = 1'b0;
   logic             sysref   = 1'b0;
   logic             linit    = 1'b0;
   logic             stall    = 1'b0;
   logic             slow     = 1'b0;
   ddcm_samp_s       samp     = '0;
   logic             in_rdy, ovld, rdy, got;
   ddcm_pair_s       odata, wd, w;
   int               err_count = 0;
   int               compares  = 0;

   ddcm_mixer dut (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .dual_mode_i(dual),
      .chan_a_bypass_i(byp_a), .chan_b_bypass_i(byp_b),
      .chan_b_input_binding_i(bind_b), .select_source_mode_i(mode),
      .chan_a_register_select_i(rsel), .chan_b_register_select_i(rsel),
      .chan_a_hop_pin0_i(pins[0]), .chan_a_hop_pin1_i(pins[1]),
      .chan_b_hop_pin0_i(pins_b[0]), .chan_b_hop_pin1_i(pins_b[1]),
      .chan_a_freq_word_i(fa), .chan_b_freq_word_i(fb),
      .chan_a_phase_offset_i(oa), .chan_b_phase_offset_i(ob),
      .sync_on_next_marker_i(snm), .sync_on_link_init_i(sli),
      .sysref_i(sysref), .link_init_i(linit), .samp_i(samp),
      .in_ready_o(in_rdy), .out_valid_o(ovld), .out_ready_i(rdy),
      .out_data_o(odata));
   ddcm_sink sink (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .out_valid_i(ovld),
      .out_data_i(odata), .stall_i(stall), .slow_i(slow),
      .out_ready_o(rdy), .got_o(got), .word_o(wd));

   // Device clock, 25 ns period
   initial forever #12.5 mclk_i = ~mclk_i;

   // Product of a sample and one table entry, as carried on the output
   function automatic logic [OUT_W-1:0] mix(input logic [SAMP_W-1:0] x,
                                            input int idx);
      logic signed [23:0] pr;
      pr = $signed(x) * $signed(SIN_LUT[idx]);
      return pr[22:7];
   endfunction
   task automatic report_and_stop();
      if (err_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // Offer one sample, hold it until taken
   task automatic put(input logic [SAMP_W-1:0] xa, input logic [SAMP_W-1:0] xb);
      int g;
      samp <= '{1'b1, xa, xb};
      for (g = 0; g < 300; g++) begin
         @(negedge mclk_i);
         if (in_rdy) break;
      end
      @(posedge mclk_i);
      if (g == 300) begin
         err_count++;
         report_and_stop();
      end
   endtask
   // Wait for the consumer to take one word
   task automatic get();
      int g;
      for (g = 0; g < 300; g++) begin
         @(posedge mclk_i);
         #1;
         if (got) break;
      end
      if (g == 300) begin
         err_count++;
         report_and_stop();
      end
      w = wd;
      @(posedge mclk_i);
   endtask
   // Checks the component whose table entry is unambiguous
   task automatic chk_ch(input ddcm_cplx_s c, input logic [SAMP_W-1:0] x,
                         input int p);
      if (p < 16) `CHK(c.q, mix(x, p))
      else `CHK(c.i, mix(x, p - 48))
   endtask

   // Main sequence
   initial begin
      int g;
      int n;
      cyc(8);
      `CHK({in_rdy, ovld, odata}, {2'b10, 64'h0})
      arst_n_i <= 1'b1;
      cyc(2);
      // Table rows; the unused select source carries a decoy code
      foreach (ROWS[r]) begin
         mode <= ROWS[r].md;
         rsel <= ROWS[r].md ? ~ROWS[r].sel : ROWS[r].sel;
         pins <= ROWS[r].md ? ROWS[r].sel : ~ROWS[r].sel;
         pins_b <= ROWS[r].md ? ROWS[r].sel : ~ROWS[r].sel;
         cyc(45);
         put(ROWS[r].xa, ROWS[r].xb);
         samp <= '0;
         get();
         chk_ch(w.a, ROWS[r].xa, PH[ROWS[r].sel]);
         chk_ch(w.b, ROWS[r].xb, PH[ROWS[r].sel]);
      end
      // Single-channel mode, then bypass of A only, then B bound to A
      mode <= 1'b0;
      rsel <= 2'h2;
      dual <= 1'b0;
      cyc(2);
      put(12'h9A5, 12'h35C);
      samp <= '0;
      get();
      `CHK(w, {12'h9A5, 4'h0, 16'h0, 12'h35C, 4'h0, 16'h0})
      dual  <= 1'b1;
      byp_a <= 1'b1;
      put(12'h9A5, 12'h35C);
      samp <= '0;
      get();
      `CHK(w.a, {12'h9A5, 4'h0, 16'h0})
      chk_ch(w.b, 12'h35C, PH[2]);
      byp_a  <= 1'b0;
      bind_b <= 1'b1;
      put(12'h9A5, 12'h35C);
      samp <= '0;
      get();
      chk_ch(w.b, 12'h9A5, PH[2]);
      // Bypass of B only, still bound to A
      byp_b <= 1'b1;
      put(12'h9A5, 12'h35C);
      samp <= '0;
      get();
      `CHK(w.b, {12'h9A5, 4'h0, 16'h0})
      chk_ch(w.a, 12'h9A5, PH[2]);
      // Hop pin change between two samples in flight, B held on its own
      byp_b  <= 1'b0;
      bind_b <= 1'b0;
      mode   <= 1'b1;
      pins   <= 2'h0;
      pins_b <= 2'h3;
      rsel   <= 2'h1;
      cyc(45);
      put(12'h400, 12'h400);
      samp <= '0;
      cyc(3);
      pins <= 2'h1;
      cyc(8);
      put(12'h400, 12'h400);
      samp <= '0;
      get();
      chk_ch(w.a, 12'h400, PH[0]);
      get();
      chk_ch(w.a, 12'h400, PH[1]);
      chk_ch(w.b, 12'h400, PH[3]);
      // Running accumulators: link sync, run unselected, then switch
      mode  <= 1'b0;
      rsel  <= 2'h0;
      fa[1] <= 32'h0001_0000;
      fb[1] <= 32'hFFFF_0000;
      oa[1] <= '0;
      ob[1] <= '0;
      cyc(2);
      sli   <= 1'b1;
      linit <= 1'b1;
      cyc(1);
      linit <= 1'b0;
      cyc(2480);
      rsel <= 2'h1;
      put(12'h3FF, 12'h3FF);
      samp <= '0;
      get();
      `CHK(w.a.q, mix(12'h3FF, 2))
      `CHK(w.b.i, mix(12'h3FF, 13))
      // Marker sync: arm with a rising edge, then one marker
      sli <= 1'b0;
      snm <= 1'b0;
      cyc(2);
      snm <= 1'b1;
      cyc(4);
      sysref <= 1'b1;
      cyc(1);
      sysref <= 1'b0;
      cyc(1480);
      put(12'h3FF, 12'h3FF);
      samp <= '0;
      get();
      `CHK(w.a.q, mix(12'h3FF, 1))
      `CHK(w.b.i, mix(12'h3FF, 14))
      // Fill with the consumer stalled until refused, then drain slowly
      dual  <= 1'b0;
      stall <= 1'b1;
      n = 0;
      for (g = 0; g < 120; g++) begin
         samp <= '{1'b1, n[11:0], 12'h0};
         @(negedge mclk_i);
         if (!in_rdy) break;
         @(posedge mclk_i);
         n++;
      end
      @(posedge mclk_i);
      samp <= '0;
      `CHK(g < 120, 1'b1)
      slow  <= 1'b1;
      stall <= 1'b0;
      for (int k = 0; k < n; k++) begin
         get();
         `CHK(w.a.i, {k[11:0], 4'h0})
      end
      cyc(50);
      `CHK(ovld, 1'b0)
      report_and_stop();
   end
endmodule
